//--- include/cpu_regs_map.svh
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

// Register indices on the software port.
`define IDX_DATA0       5'h00
`define IDX_DATA1       5'h01
`define IDX_DATA2       5'h02
`define IDX_DATA3       5'h03
`define IDX_ADDR0       5'h04
`define IDX_ADDR1       5'h05
`define IDX_FRAME       5'h06
`define IDX_VECTOR      5'h07
`define IDX_PC          5'h08
`define IDX_USER_SP     5'h09
`define IDX_INT_SP      5'h0A
`define IDX_STATIC      5'h0B
`define IDX_FLAGS       5'h0C
`define IDX_D0_UPPER    5'h0D
`define IDX_D0_LOWER    5'h0E
`define IDX_D1_UPPER    5'h0F
`define IDX_D1_LOWER    5'h10
`define IDX_PAIR_LOW    5'h11
`define IDX_PAIR_HIGH   5'h12
`define IDX_ADDR_PAIR   5'h13
`define IDX_ACTIVE_SP   5'h14

// Flag bit positions.
`define FLAG_C          0
`define FLAG_D          1
`define FLAG_Z          2
`define FLAG_S          3
`define FLAG_B          4
`define FLAG_O          5
`define FLAG_I          6
`define FLAG_U          7
`define FLAG_PRIO_LSB   8
`define FLAG_PRIO_MSB   10

// Reset values.
`define RST_WORD        16'h0000
`define RST_ADDR20      20'h0_0000
`define RST_FLAGS       11'h000

// Highest software interrupt number that moves to the interrupt stack.
`define SWI_STACK_MAX   6'h1F

`endif

//--- include/cpu_regs_pkg.sv
package cpu_regs_pkg;

    typedef logic [4:0] idx_t;

    // Whole state of the register set, one flop per bit.
    typedef struct packed {
        logic [1:0][3:0][15:0] data;
        logic [1:0][1:0][15:0] addr;
        logic [1:0][15:0]      frame;
        logic [19:0]           vector;
        logic [19:0]           pc;
        logic [15:0]           user_sp;
        logic [15:0]           int_sp;
        logic [15:0]           sbase;
        logic [10:0]           flags;
        logic [31:0]           rdata;
        logic [31:0]           opnd;
        logic [15:0]           sp_act;
        logic                  int_ok;
    } state_s;

endpackage : cpu_regs_pkg

//--- design/cpu_register_set.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"

module cpu_register_set
    import cpu_regs_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    input  wire logic [4:0]  opnd_sel,
    output var  logic [31:0] opnd_data,
    input  wire logic        wb_we,
    input  wire logic [4:0]  wb_sel,
    input  wire logic [31:0] wb_data,
    input  wire logic        alu_flag_we,
    input  wire logic        alu_carry,
    input  wire logic        alu_overflow,
    input  wire logic [15:0] alu_result,
    input  wire logic        pc_load,
    input  wire logic [19:0] pc_next,
    input  wire logic        int_ack,
    input  wire logic        swi_exec,
    input  wire logic [5:0]  swi_num,
    input  wire logic [2:0]  int_level,
    output var  logic        int_enabled,
    output var  logic [10:0] flag_state,
    output var  logic [19:0] pc_value,
    output var  logic [15:0] sp_value
);

    state_s st_ff;
    state_s nxt_st;

    // Read mux shared by the software port and the operand port.
    // Banked registers always come from the bank the flag selects.
    function automatic logic [31:0] reg_read(state_s s, idx_t idx);
        logic        b;
        logic [31:0] v;
        b = s.flags[`FLAG_B];
        v = '0;
        case (idx)
            `IDX_DATA0:     v = {16'h0000, s.data[b][0]};
            `IDX_DATA1:     v = {16'h0000, s.data[b][1]};
            `IDX_DATA2:     v = {16'h0000, s.data[b][2]};
            `IDX_DATA3:     v = {16'h0000, s.data[b][3]};
            `IDX_ADDR0:     v = {16'h0000, s.addr[b][0]};
            `IDX_ADDR1:     v = {16'h0000, s.addr[b][1]};
            `IDX_FRAME:     v = {16'h0000, s.frame[b]};
            `IDX_VECTOR:    v = {12'h000, s.vector};
            `IDX_PC:        v = {12'h000, s.pc};
            `IDX_USER_SP:   v = {16'h0000, s.user_sp};
            `IDX_INT_SP:    v = {16'h0000, s.int_sp};
            `IDX_STATIC:    v = {16'h0000, s.sbase};
            // Bits above the flags read as zero.
            `IDX_FLAGS:     v = {21'h00_0000, s.flags};
            `IDX_D0_UPPER:  v = {24'h00_0000, s.data[b][0][15:8]};
            `IDX_D0_LOWER:  v = {24'h00_0000, s.data[b][0][7:0]};
            `IDX_D1_UPPER:  v = {24'h00_0000, s.data[b][1][15:8]};
            `IDX_D1_LOWER:  v = {24'h00_0000, s.data[b][1][7:0]};
            `IDX_PAIR_LOW:  v = {s.data[b][2], s.data[b][0]};
            `IDX_PAIR_HIGH: v = {s.data[b][3], s.data[b][1]};
            `IDX_ADDR_PAIR: v = {s.addr[b][1], s.addr[b][0]};
            `IDX_ACTIVE_SP: begin
                // Stack flag zero picks the interrupt stack.
                v = {16'h0000, s.flags[`FLAG_U] ? s.user_sp
                                                : s.int_sp};
            end
            default:        v = '0;
        endcase
        return v;
    endfunction : reg_read

    // Write decode shared by both write ports. Byte writes leave the
    // other half untouched; unmapped indices are ignored.
    function automatic state_s reg_write(state_s s, idx_t idx,
                                         logic [31:0] d);
        state_s r;
        logic   b;
        r = s;
        b = s.flags[`FLAG_B];
        case (idx)
            `IDX_DATA0:     r.data[b][0] = d[15:0];
            `IDX_DATA1:     r.data[b][1] = d[15:0];
            `IDX_DATA2:     r.data[b][2] = d[15:0];
            `IDX_DATA3:     r.data[b][3] = d[15:0];
            `IDX_ADDR0:     r.addr[b][0] = d[15:0];
            `IDX_ADDR1:     r.addr[b][1] = d[15:0];
            `IDX_FRAME:     r.frame[b] = d[15:0];
            `IDX_VECTOR:    r.vector = d[19:0];
            `IDX_PC:        r.pc = d[19:0];
            `IDX_USER_SP:   r.user_sp = d[15:0];
            `IDX_INT_SP:    r.int_sp = d[15:0];
            `IDX_STATIC:    r.sbase = d[15:0];
            // The debug bit is stored as written; keeping it zero is
            // up to software.
            `IDX_FLAGS:     r.flags = d[10:0];
            `IDX_D0_UPPER:  r.data[b][0][15:8] = d[7:0];
            `IDX_D0_LOWER:  r.data[b][0][7:0] = d[7:0];
            `IDX_D1_UPPER:  r.data[b][1][15:8] = d[7:0];
            `IDX_D1_LOWER:  r.data[b][1][7:0] = d[7:0];
            `IDX_PAIR_LOW: begin
                r.data[b][0] = d[15:0];
                r.data[b][2] = d[31:16];
            end
            `IDX_PAIR_HIGH: begin
                r.data[b][1] = d[15:0];
                r.data[b][3] = d[31:16];
            end
            `IDX_ADDR_PAIR: begin
                r.addr[b][0] = d[15:0];
                r.addr[b][1] = d[31:16];
            end
            `IDX_ACTIVE_SP: begin
                if (s.flags[`FLAG_U]) begin
                    r.user_sp = d[15:0];
                end else begin
                    r.int_sp = d[15:0];
                end
            end
            default:        r = s;
        endcase
        return r;
    endfunction : reg_write

    // Next-state logic. Later updates take priority over earlier ones:
    // writeback, then software write, then ALU flags, then interrupt
    // events, so an acknowledge in the same cycle as a flag write still
    // closes the interrupt gate and switches to the interrupt stack.
    always_comb begin
        nxt_st = st_ff;
        if (pc_load) begin
            nxt_st.pc = pc_next;
        end
        if (wb_we) begin
            nxt_st = reg_write(nxt_st, wb_sel, wb_data);
        end
        if (reg_wr) begin
            nxt_st = reg_write(nxt_st, reg_addr, reg_wdata);
        end
        if (alu_flag_we) begin
            nxt_st.flags[`FLAG_C] = alu_carry;
            nxt_st.flags[`FLAG_Z] = (alu_result == 16'h0000);
            nxt_st.flags[`FLAG_S] = alu_result[15];
            nxt_st.flags[`FLAG_O] = alu_overflow;
        end
        if (int_ack) begin
            nxt_st.flags[`FLAG_I] = 1'b0;
            nxt_st.flags[`FLAG_U] = 1'b0;
        end
        if (swi_exec) begin
            nxt_st.flags[`FLAG_I] = 1'b0;
            if (swi_num <= `SWI_STACK_MAX) begin
                nxt_st.flags[`FLAG_U] = 1'b0;
            end
        end
        // Read data stand only in the cycle after the strobe.
        nxt_st.rdata = reg_rd ? reg_read(st_ff, reg_addr) : '0;
        // Operand port always follows its select, one cycle later.
        nxt_st.opnd = reg_read(st_ff, opnd_sel);
        nxt_st.sp_act = nxt_st.flags[`FLAG_U] ? nxt_st.user_sp
                                              : nxt_st.int_sp;
        // Gate uses the updated flags, so a request level seen in one
        // cycle is judged against the flags of the next.
        nxt_st.int_ok = nxt_st.flags[`FLAG_I] &&
            (int_level >
             nxt_st.flags[`FLAG_PRIO_MSB:`FLAG_PRIO_LSB]);
    end

    // State register; reset takes constants only.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff.data   <= {8{`RST_WORD}};
            st_ff.addr   <= {4{`RST_WORD}};
            st_ff.frame  <= {2{`RST_WORD}};
            st_ff.vector <= `RST_ADDR20;
            st_ff.pc     <= `RST_ADDR20;
            st_ff.user_sp <= `RST_WORD;
            st_ff.int_sp  <= `RST_WORD;
            st_ff.sbase  <= `RST_WORD;
            st_ff.flags  <= `RST_FLAGS;
            st_ff.rdata  <= '0;
            st_ff.opnd   <= '0;
            st_ff.sp_act <= `RST_WORD;
            st_ff.int_ok <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state flops.
    assign reg_rdata   = st_ff.rdata;
    assign opnd_data   = st_ff.opnd;
    assign int_enabled = st_ff.int_ok;
    assign flag_state  = st_ff.flags;
    assign pc_value    = st_ff.pc;
    assign sp_value    = st_ff.sp_act;

endmodule : cpu_register_set

`default_nettype wire

//--- verif/cpu_register_set_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"
// Port-level checks of flag, counter and read-port behaviour.
module cpu_register_set_asserts (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [4:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        wb_we,
    input wire logic        alu_flag_we,
    input wire logic        alu_carry,
    input wire logic        alu_overflow,
    input wire logic [15:0] alu_result,
    input wire logic        int_ack,
    input wire logic        swi_exec,
    input wire logic [5:0]  swi_num,
    input wire logic [2:0]  int_level,
    input wire logic        int_enabled,
    input wire logic [10:0] flag_state,
    input wire logic [19:0] pc_value
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // A flag write that no hardware event overrides in the same cycle.
    sequence flag_sw_wr;
        reg_wr && reg_addr == `IDX_FLAGS && !wb_we && !alu_flag_we
            && !int_ack && !swi_exec;
    endsequence
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
    AST_ACK_CLR: assert property (int_ack |=> flag_state[7:6] == 2'h0)
        else $error("acknowledge left I or U set");
    AST_SWI_LOW: assert property (swi_exec && swi_num <= `SWI_STACK_MAX
        |=> flag_state[7:6] == 2'h0) else $error("low swi left I or U set");
    AST_SWI_HIGH: assert property (swi_exec && swi_num > `SWI_STACK_MAX
        && !int_ack && !reg_wr && !wb_we |=> !flag_state[6]
        && $stable(flag_state[7])) else $error("high swi changed U");
    AST_CARRY_OVF: assert property (alu_flag_we |=> flag_state[0] ==
        $past(alu_carry) && flag_state[5] == $past(alu_overflow))
        else $error("carry or overflow wrong");
    AST_ZERO_SIGN: assert property (alu_flag_we |=> flag_state[3] ==
        $past(alu_result[15]) && flag_state[2] == ($past(alu_result) == 16'h0))
        else $error("zero or sign wrong");
    AST_INT_GATE: assert property (int_enabled == (flag_state[6]
        && $past(int_level) > flag_state[10:8])) else $error("gate wrong");
    AST_FLAG_WR: assert property (flag_sw_wr |=>
        flag_state == $past(reg_wdata[10:0])) else $error("flag write lost");
    AST_PC_WR: assert property (reg_wr && reg_addr == `IDX_PC && !wb_we
        |=> pc_value == $past(reg_wdata[19:0])) else $error("pc write lost");
endmodule : cpu_register_set_asserts
`default_nettype wire

//--- verif/test_cpu_register_set.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_regs_map.svh"
module test_cpu_register_set;
    logic        clock, rst, reg_wr, reg_rd, wb_we, alu_flag_we, alu_carry;
    logic        alu_overflow, pc_load, int_ack, swi_exec, int_enabled;
    logic [4:0]  reg_addr, opnd_sel, wb_sel;
    logic [31:0] reg_wdata, reg_rdata, opnd_data, wb_data, v;
    logic [15:0] alu_result, sp_value;
    logic [19:0] pc_next, pc_value;
    logic [10:0] flag_state;
    logic [5:0]  swi_num;
    logic [2:0]  int_level;
    int          error_cnt, check_count;

    cpu_register_set dut (.*);

    // Core clock, 100 ns period.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Strobes wait an edge first so no signal is assigned twice at once.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd

    // Core event pulse; m = {pc, wb, swi, ack, alu}, d carries the data.
    task automatic ev(input logic [4:0] m, input logic [19:0] d);
        @(posedge clock);
        {pc_load, wb_we, swi_exec, int_ack, alu_flag_we} <= m;
        {alu_overflow, alu_carry, alu_result} <= d[17:0];
        {swi_num, pc_next, wb_data} <= {d[5:0], d, 12'h000, d};
        @(posedge clock);
        {pc_load, wb_we, swi_exec, int_ack, alu_flag_we} <= 5'h00;
        #1;
    endtask : ev

    // Hang guard well beyond the length of the sequence.
    initial begin
        #2_000_000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        {reg_wr, reg_rd, wb_we, alu_flag_we, pc_load, int_ack, swi_exec} = '0;
        {alu_carry, alu_overflow, reg_addr, reg_wdata, alu_result} = '0;
        {pc_next, swi_num, int_level, wb_data, error_cnt, check_count} = '0;
        {rst, opnd_sel, wb_sel} = {1'b1, `IDX_PC, `IDX_STATIC};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(`IDX_FLAGS, 32'h0000_0000);
        for (int i = 0; i < 12; i++) wr(i[4:0], 32'hFFF5_A5A0 + i);
        for (int i = 0; i < 12; i++) begin
            v = (i == 7 || i == 8) ? 32'h000F_FFFF : 32'h0000_FFFF;
            rd(i[4:0], v & (32'hFFF5_A5A0 + i));
        end
        wr(5'h15, 32'h1234_5678);
        rd(5'h15, 32'h0000_0000);
        $display("test widths done");
        wr(`IDX_D0_UPPER, 32'h0000_00AB);
        wr(`IDX_D1_LOWER, 32'h0000_00CD);
        rd(`IDX_DATA0, 32'h0000_ABA0);
        rd(`IDX_DATA1, 32'h0000_A5CD);
        rd(`IDX_PAIR_LOW, 32'hA5A2_ABA0);
        wr(`IDX_PAIR_HIGH, 32'h1357_2468);
        rd(`IDX_DATA3, 32'h0000_1357);
        rd(`IDX_ADDR_PAIR, 32'hA5A5_A5A4);
        $display("test halves done");
        wr(`IDX_FLAGS, 32'h0000_0010);
        rd(`IDX_DATA1, 32'h0000_0000);
        wr(`IDX_DATA0, 32'h0000_5555);
        rd(`IDX_DATA0, 32'h0000_5555);
        wr(`IDX_FLAGS, 32'h0000_0080);
        rd(`IDX_DATA0, 32'h0000_ABA0);
        chk({16'h0000, sp_value}, 32'h0000_A5A9);
        wr(`IDX_FLAGS, 32'h0000_0000);
        rd(`IDX_ACTIVE_SP, 32'h0000_A5AA);
        $display("test banks done");
        ev(5'h01, 20'h1_0000);
        chk({21'h0, flag_state}, 32'h0000_0005);
        ev(5'h01, 20'h2_8000);
        chk({21'h0, flag_state}, 32'h0000_0028);
        wr(`IDX_FLAGS, 32'h0000_03C0);
        for (int i = 3; i < 5; i++) begin
            @(posedge clock);
            int_level <= i[2:0];
            repeat (2) @(posedge clock);
            #1 chk({31'h0, int_enabled}, {31'h0, i == 4});
        end
        ev(5'h02, 20'h0_0000);
        chk({21'h0, flag_state}, 32'h0000_0300);
        chk({31'h0, int_enabled}, 32'h0000_0000);
        wr(`IDX_FLAGS, 32'h0000_03C0);
        ev(5'h04, 20'h0_0020);
        chk({21'h0, flag_state}, 32'h0000_0380);
        wr(`IDX_FLAGS, 32'h0000_03C0);
        ev(5'h04, 20'h0_001F);
        chk({21'h0, flag_state}, 32'h0000_0300);
        $display("test flags done");
        ev(5'h08, 20'h0_BEEF);
        rd(`IDX_STATIC, 32'h0000_BEEF);
        ev(5'h10, 20'hA_BCDE);
        chk({12'h000, pc_value}, 32'h000A_BCDE);
        @(posedge clock);
        #1 chk(opnd_data, 32'h000A_BCDE);
        $display("test core done");
        give_verdict();
    end
endmodule : test_cpu_register_set
bind cpu_register_set cpu_register_set_asserts chk_i (.*);
`default_nettype wire
